// ===== hdl/bpc_pkg.sv
// package of constants for the eight-pin bidirectional port
// assumes an ahb-lite slave of 32-bit words and one 100 MHz clock

package bpc_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [11:0] BPC_OFS_PIN = 12'h000;
   localparam logic [11:0] BPC_OFS_LATCH = 12'h004;
   localparam logic [11:0] BPC_OFS_DIR = 12'h008;
   localparam logic [11:0] BPC_OFS_CFG = 12'h00c;
   localparam int BPC_DEC_W = 12;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [7:0] BPC_RST_DIR = 8'hff;
   localparam logic [7:0] BPC_RST_LATCH = 8'h00;
   localparam logic [1:0] BPC_RST_CFG = 2'h1;
   localparam logic [31:0] BPC_RST_RDATA = 32'h0000_0000;

   // ************************************************************
   // field positions in the configuration register
   // ************************************************************
   localparam int BPC_CFG_ROUTE = 0;
   localparam int BPC_CFG_FLOAT = 1;
   localparam int BPC_CFG_W = 2;

   // ************************************************************
   // pins with a fixed alternate use
   // ************************************************************
   localparam int BPC_PIN_OSC_OUT = 0;
   localparam int BPC_PIN_OSC_IN = 1;
   localparam int BPC_PIN_SCC = 1;
   localparam int BPC_PIN_ECC = 2;

   // ************************************************************
   // bus encodings
   // ************************************************************
   localparam logic [1:0] BPC_HRESP_OKAY = 2'h0;

endpackage

// ===== hdl/bpc_pin_mux.sv
// one pin of the port: picks the driver and the digital input level
// assumes its take signals come decoded and stable from the port top
`timescale 1ns/1ps
`default_nettype none

module bpc_pin_mux (
   // software state
   input wire logic lat_bit,
   input wire logic dir_bit,
   // pad level
   input wire logic pin_bit,
   // oscillator claim
   input wire logic osc_take,
   // serial unit claim
   input wire logic ser_take,
   input wire logic ser_drive,
   input wire logic ser_data,
   // compare or pwm output claim
   input wire logic per_take,
   input wire logic per_data,
   input wire logic per_float,
   // results
   output logic drive_out,
   output logic drive_en,
   output logic digital_in
);

   // ************************************************************
   // priority: oscillator, serial unit, then direction bit
   // ************************************************************

   // driver choice
   always_comb begin
      drive_out = 1'b0;
      drive_en = 1'b0;
      if (osc_take) begin
         drive_out = 1'b0;
         drive_en = 1'b0;
      end else if (ser_take) begin
         drive_out = ser_data;
         drive_en = ser_drive;
      end else if (!dir_bit) begin
         drive_en = 1'b1;
         drive_out = per_take ? per_data : lat_bit;
         if (per_take && per_float) begin
            drive_en = 1'b0;
         end
      end else begin
         drive_en = 1'b0;
      end
   end

   // digital input is cut while the oscillator owns the pad
   assign digital_in = osc_take ? 1'b0 : pin_bit;

endmodule

`default_nettype wire

// ===== hdl/bpc_port.sv
// top of the eight-pin bidirectional port with peripheral overrides
// assumes a single ahb-lite master, pins synchronous to hclk, and
// peripheral control levels that are already synchronous to hclk
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module bpc_port #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // package pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   // timer oscillator and counter clock
   input wire logic timer_osc_enable,
   output logic timer_osc_analog_en,
   output logic timer_counter_clock_input,
   // second capture compare channel
   input wire logic scc_out_active,
   input wire logic scc_out,
   output logic scc_capture_in,
   output logic scc_on_alternate_pin,
   // enhanced capture compare channel
   input wire logic ecc_out_active,
   input wire logic ecc_out,
   input wire logic ecc_pwm_a_mode,
   input wire logic ecc_shutdown,
   output logic ecc_capture_in,
   // asynchronous serial unit overrides
   input wire logic [WIDTH-1:0] async_ser_take,
   input wire logic [WIDTH-1:0] async_ser_drive,
   input wire logic [WIDTH-1:0] async_ser_data,
   // synchronous serial unit overrides
   input wire logic [WIDTH-1:0] sync_ser_take,
   input wire logic [WIDTH-1:0] sync_ser_drive,
   input wire logic [WIDTH-1:0] sync_ser_data,
   // pin levels seen by the serial units
   output logic [WIDTH-1:0] serial_pin_in
);

   import bpc_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************

   // software registers
   logic [WIDTH-1:0] port_output_latch;
   logic [WIDTH-1:0] next_port_output_latch;
   logic [WIDTH-1:0] port_direction_control;
   logic [WIDTH-1:0] next_port_direction_control;
   logic [BPC_CFG_W-1:0] port_config;
   logic [BPC_CFG_W-1:0] next_port_config;

   // sampled pin levels
   logic [WIDTH-1:0] pin_sample;
   logic [WIDTH-1:0] next_pin_sample;

   // data phase state
   logic dp_write;
   logic next_dp_write;
   logic [BPC_DEC_W-1:0] dp_addr;
   logic [BPC_DEC_W-1:0] next_dp_addr;
   logic [31:0] next_hrdata;

   // pin drivers
   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] next_pin_oe;

   // decoded pin claims
   logic ap_valid;
   logic ccp_second_route_select;
   logic float_on_shutdown;
   logic [WIDTH-1:0] osc_take;
   logic [WIDTH-1:0] ser_take;
   logic [WIDTH-1:0] ser_drive;
   logic [WIDTH-1:0] ser_data;
   logic [WIDTH-1:0] per_take;
   logic [WIDTH-1:0] per_data;
   logic [WIDTH-1:0] per_float;
   logic [WIDTH-1:0] digital_in;

   // ************************************************************
   // read data word
   // ************************************************************

   // narrow registers sit in the low bits, the rest reads zero
   // the function only picks a word; all timing stays in the caller
   function automatic logic [31:0] read_word(
      input logic [BPC_DEC_W-1:0] addr,
      input logic [WIDTH-1:0] pins,
      input logic [WIDTH-1:0] latch,
      input logic [WIDTH-1:0] dir,
      input logic [BPC_CFG_W-1:0] cfg
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      unique case (addr)
         BPC_OFS_PIN: word[WIDTH-1:0] = pins;
         BPC_OFS_LATCH: word[WIDTH-1:0] = latch;
         BPC_OFS_DIR: word[WIDTH-1:0] = dir;
         BPC_OFS_CFG: word[BPC_CFG_W-1:0] = cfg;
         default: word = 32'h0000_0000;
      endcase
      return word;
   endfunction

   // ************************************************************
   // ahb-lite slave
   // ************************************************************

   // zero wait states, so the slave never stretches a transfer
   assign hreadyout = 1'b1;
   assign hresp = BPC_HRESP_OKAY[0];

   // a transfer is taken only on nonseq or seq with hready high;
   // idle and busy cycles clear dp_write and leave dp_addr untouched,
   // and an unmapped address still answers okay and reads zero
   assign ap_valid = hsel & htrans[1] & hready;

   // address phase capture
   always_comb begin
      next_dp_write = 1'b0;
      next_dp_addr = dp_addr;
      if (ap_valid) begin
         next_dp_write = hwrite;
         next_dp_addr = haddr[BPC_DEC_W-1:0];
      end
   end

   // read data is taken from next values, so a read that follows
   // a write at once already sees the written data
   always_comb begin
      next_hrdata = hrdata;
      if (ap_valid && !hwrite) begin
         next_hrdata = read_word(haddr[BPC_DEC_W-1:0],
                                 next_pin_sample,
                                 next_port_output_latch,
                                 next_port_direction_control,
                                 next_port_config);
      end
   end

   // bus state registers; dp_addr keeps its value between transfers
   // so an idle bus does not toggle the decoder
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= BPC_OFS_PIN;
         hrdata <= BPC_RST_RDATA;
      end else begin
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
      end
   end

   // ************************************************************
   // software registers
   // ************************************************************

   // hsize is not checked; only whole-word writes are expected
   // a byte or halfword write would still load the whole register,
   // so software must not rely on narrow stores to keep other bits
   always_comb begin
      next_port_output_latch = port_output_latch;
      next_port_direction_control = port_direction_control;
      next_port_config = port_config;
      if (dp_write) begin
         unique case (dp_addr)
            BPC_OFS_PIN: begin
               next_port_output_latch = hwdata[WIDTH-1:0];
            end
            BPC_OFS_LATCH: begin
               next_port_output_latch = hwdata[WIDTH-1:0];
            end
            BPC_OFS_DIR: begin
               next_port_direction_control = hwdata[WIDTH-1:0];
            end
            BPC_OFS_CFG: begin
               next_port_config = hwdata[BPC_CFG_W-1:0];
            end
            default: begin
               next_port_config = port_config;
            end
         endcase
      end
   end

   // register state; overrides never write the direction bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_output_latch <= BPC_RST_LATCH[WIDTH-1:0];
         port_direction_control <= BPC_RST_DIR[WIDTH-1:0];
         port_config <= BPC_RST_CFG;
      end else begin
         port_output_latch <= next_port_output_latch;
         port_direction_control <= next_port_direction_control;
         port_config <= next_port_config;
      end
   end

   // ************************************************************
   // peripheral claims on the pins
   // ************************************************************

   // claims are plain levels from the peripherals; the pin mux ranks
   // them, so the direction bits never need to be rewritten here
   // route and float bits of the configuration register
   assign ccp_second_route_select = port_config[BPC_CFG_ROUTE];
   assign float_on_shutdown = port_config[BPC_CFG_FLOAT];

   // where both serial units claim a pin, the synchronous one wins
   always_comb begin
      ser_take = async_ser_take | sync_ser_take;
      ser_drive = async_ser_drive;
      ser_data = async_ser_data;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_ser_take[i]) begin
            ser_drive[i] = sync_ser_drive[i];
            ser_data[i] = sync_ser_data[i];
         end
      end
   end

   // fixed alternate functions on the low pins
   always_comb begin
      osc_take = '0;
      per_take = '0;
      per_data = '0;
      per_float = '0;
      osc_take[BPC_PIN_OSC_OUT] = timer_osc_enable;
      osc_take[BPC_PIN_OSC_IN] = timer_osc_enable;
      per_take[BPC_PIN_SCC] = ccp_second_route_select & scc_out_active;
      per_data[BPC_PIN_SCC] = scc_out;
      per_take[BPC_PIN_ECC] = ecc_out_active;
      per_data[BPC_PIN_ECC] = ecc_out;
      per_float[BPC_PIN_ECC] = ecc_pwm_a_mode & float_on_shutdown
                               & ecc_shutdown;
   end

   // ************************************************************
   // per pin multiplexers
   // ************************************************************

   for (genvar g = 0; g < WIDTH; g++) begin : g_pin
      bpc_pin_mux u_mux (
         .lat_bit(port_output_latch[g]),
         .dir_bit(port_direction_control[g]),
         .pin_bit(pin_in[g]),
         .osc_take(osc_take[g]),
         .ser_take(ser_take[g]),
         .ser_drive(ser_drive[g]),
         .ser_data(ser_data[g]),
         .per_take(per_take[g]),
         .per_data(per_data[g]),
         .per_float(per_float[g]),
         .drive_out(next_pin_out[g]),
         .drive_en(next_pin_oe[g]),
         .digital_in(digital_in[g])
      );
   end

   // ************************************************************
   // pin drivers and samples
   // ************************************************************

   // one register stage: pins follow a register write one edge later;
   // registering the drivers keeps decode glitches off the pads, at
   // the cost of that cycle of lag after every change of a claim
   assign next_pin_sample = digital_in;

   // driver and sample registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= '0;
         pin_oe <= '0;
         pin_sample <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         pin_sample <= next_pin_sample;
      end
   end

   // ************************************************************
   // inputs handed to the peripherals
   // ************************************************************

   // the oscillator pads are analog while the oscillator runs
   assign timer_osc_analog_en = timer_osc_enable;

   // counter clock sees the sampled level, zero while osc runs
   assign timer_counter_clock_input = pin_sample[BPC_PIN_OSC_OUT];

   assign scc_capture_in = ccp_second_route_select
                           & port_direction_control[BPC_PIN_SCC]
                           & pin_sample[BPC_PIN_SCC];

   // tells the other port to host the second channel
   assign scc_on_alternate_pin = ~ccp_second_route_select;

   assign ecc_capture_in = port_direction_control[BPC_PIN_ECC]
                           & pin_sample[BPC_PIN_ECC];

   // serial receivers read the sampled pads; the oscillator pins read
   // zero here while the oscillator runs, like every digital reader
   assign serial_pin_in = pin_sample;

endmodule

`default_nettype wire

// ===== tb/bpc_pins_model.sv
// pad side of the port: external drivers and the wire level per pin
// assumes pin_out and pin_oe change just after a rising hclk edge
`timescale 1ns/1ps
`default_nettype none

module bpc_pins_model (
   // clock
   input wire logic hclk,
   // device drivers
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // bench drivers
   input wire logic [7:0] ext_lvl,
   input wire logic [7:0] ext_drv,
   // wire level
   output logic [7:0] pin_in
);
   // ************************************************************
   // wire resolution
   // ************************************************************
   logic [7:0] drv;
   logic [7:0] lvl;
   logic [7:0] last = 8'h00;

   // device wins where enabled; the bench never drives against it
   assign drv = pin_oe | ext_drv;
   assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

   // an undriven pad has no pull, so it shows the inverse of the level
   // last driven, which a stale sample inside the port cannot match
   always @(posedge hclk) begin
      last <= (drv & lvl) | (~drv & last);
   end
   assign pin_in = (drv & lvl) | (~drv & ~last);
endmodule

`default_nettype wire

// ===== tb/bpc_port_props.sv
// checker for the port top: bus answer, pin drivers and samples
// assumes it is bound to bpc_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module bpc_port_props #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   // peripherals
   input wire logic timer_osc_enable,
   input wire logic timer_osc_analog_en,
   input wire logic scc_capture_in,
   input wire logic scc_on_alternate_pin,
   input wire logic ecc_capture_in,
   input wire logic [WIDTH-1:0] sync_ser_take,
   input wire logic [WIDTH-1:0] sync_ser_drive,
   input wire logic [WIDTH-1:0] serial_pin_in
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // pin levels one edge back, unreset: guarded by $past(hresetn)
   logic [WIDTH-1:0] pin_d;
   always_ff @(posedge hclk) begin
      pin_d <= pin_in;
   end

   property p_ready;
      hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready)
      else $error("bus answer not ready or not okay");
   property p_upper;
      hrdata[31:8] == 24'h00_0000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("read data upper bits set");
   property p_sample;
      $past(hresetn) |-> serial_pin_in[WIDTH-1:2] == pin_d[WIDTH-1:2];
   endproperty
   a_sample: assert property (p_sample)
      else $error("pin sample not one edge behind pad");
   property p_reset_in;
      $rose(hresetn) |-> pin_oe == '0;
   endproperty
   a_reset_in: assert property (p_reset_in)
      else $error("driver on right after reset");
   property p_osc_pins;
      timer_osc_enable |=> pin_oe[1:0] == 2'b00 && pin_out[1:0] == 2'b00;
   endproperty
   a_osc_pins: assert property (p_osc_pins)
      else $error("oscillator pins still digital");
   property p_osc_analog;
      timer_osc_analog_en == timer_osc_enable;
   endproperty
   a_osc_analog: assert property (p_osc_analog)
      else $error("oscillator enable not passed on");
   property p_osc_in;
      timer_osc_enable |=> serial_pin_in[1:0] == 2'b00;
   endproperty
   a_osc_in: assert property (p_osc_in)
      else $error("oscillator pins still read as digital input");
   property p_ser_take;
      $past(hresetn) && !$past(timer_osc_enable) |->
         (pin_oe & $past(sync_ser_take)) ==
         ($past(sync_ser_drive) & $past(sync_ser_take));
   endproperty
   a_ser_take: assert property (p_ser_take)
      else $error("serial direction override ignored");
   property p_scc_cap;
      scc_capture_in |-> !scc_on_alternate_pin && pin_d[1];
   endproperty
   a_scc_cap: assert property (p_scc_cap)
      else $error("second channel capture without cause");
   property p_ecc_cap;
      ecc_capture_in |-> pin_d[2];
   endproperty
   a_ecc_cap: assert property (p_ecc_cap)
      else $error("enhanced channel capture without cause");
endmodule

`default_nettype wire

// ===== tb/bpc_port_tb.sv
// testbench for the port: ahb-lite tasks, pin model, fixed sequence
// assumes the pin model and checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module bpc_port_tb;
   import bpc_pkg::*;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] pin_in, pin_out, pin_oe, ext_lvl, ext_drv, serial_pin_in;
   logic [7:0] async_ser_take, async_ser_drive, async_ser_data;
   logic [7:0] sync_ser_take, sync_ser_drive, sync_ser_data;
   logic timer_osc_enable, timer_osc_analog_en, timer_counter_clock_input;
   logic scc_out_active, scc_out, scc_capture_in, scc_on_alternate_pin;
   logic ecc_out_active, ecc_out, ecc_pwm_a_mode, ecc_shutdown;
   logic ecc_capture_in;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   bpc_port #(.WIDTH(8)) dut (.*);
   bpc_pins_model pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pin_in(pin_in));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // one single transfer; waits on hready, the timeout bounds the wait
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {20'h0_0000, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask

   // drivers are registered, so let three edges land before looking
   task automatic settle;
      repeat (3) @(posedge hclk);
      #1;
   endtask

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         close_out;
      end
   end

   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {async_ser_take, async_ser_drive, async_ser_data} = '0;
      {sync_ser_take, sync_ser_drive, sync_ser_data} = '0;
      {timer_osc_enable, scc_out_active, scc_out} = '0;
      {ecc_out_active, ecc_out, ecc_pwm_a_mode, ecc_shutdown} = '0;
      ext_drv = 8'hff;
      ext_lvl = 8'h00;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      settle;
      chk(pin_oe, 8'h00);
      rc(BPC_OFS_DIR, 8'hff);
      rc(BPC_OFS_LATCH, 8'h00);
      rc(BPC_OFS_CFG, 8'h01);
      @(posedge hclk);
      ext_drv <= 8'h00;
      wr(BPC_OFS_LATCH, 8'ha5);
      wr(BPC_OFS_DIR, 8'h00);
      settle;
      chk({pin_oe, pin_out}, 16'hffa5);
      rc(BPC_OFS_PIN, 8'ha5);
      wr(BPC_OFS_DIR, 8'h0f);
      settle;
      @(posedge hclk);
      ext_lvl <= 8'h0d;
      ext_drv <= 8'h0f;
      settle;
      chk(pin_oe, 8'hf0);
      chk(timer_counter_clock_input, 1'b1);
      rc(BPC_OFS_PIN, 8'had);
      rc(BPC_OFS_LATCH, 8'ha5);
      wr(BPC_OFS_PIN, 8'h3c);
      rc(BPC_OFS_LATCH, 8'h3c);
      // sync unit drives pins 6 and 5 over async; async drives 7, reads 4
      @(posedge hclk);
      sync_ser_take <= 8'h60;
      sync_ser_drive <= 8'h60;
      sync_ser_data <= 8'h40;
      async_ser_take <= 8'hb0;
      async_ser_drive <= 8'h80;
      async_ser_data <= 8'ha0;
      ext_drv <= 8'h10;
      ext_lvl <= 8'h10;
      wr(BPC_OFS_DIR, 8'h00);
      settle;
      chk({pin_oe, pin_out & pin_oe}, 16'hefcc);
      chk(serial_pin_in[4], 1'b1);
      rc(BPC_OFS_DIR, 8'h00);
      @(posedge hclk);
      sync_ser_take <= 8'h00;
      async_ser_take <= 8'h00;
      ext_drv <= 8'h00;
      timer_osc_enable <= 1'b1;
      settle;
      chk({pin_oe, timer_osc_analog_en, timer_counter_clock_input},
         10'h3f2);
      @(posedge hclk);
      timer_osc_enable <= 1'b0;
      scc_out_active <= 1'b1;
      scc_out <= 1'b1;
      settle;
      chk(pin_out[1], 1'b1);
      wr(BPC_OFS_CFG, 8'h00);
      settle;
      chk({scc_on_alternate_pin, pin_out[1]}, 2'b10);
      wr(BPC_OFS_CFG, 8'h01);
      wr(BPC_OFS_DIR, 8'h02);
      settle;
      @(posedge hclk);
      ext_drv <= 8'h02;
      ext_lvl <= 8'h02;
      settle;
      chk({scc_capture_in, pin_oe[1]}, 2'b10);
      @(posedge hclk);
      ext_drv <= 8'h00;
      scc_out_active <= 1'b0;
      ecc_out_active <= 1'b1;
      wr(BPC_OFS_DIR, 8'h00);
      settle;
      chk(pin_out[2], 1'b0);
      @(posedge hclk);
      ecc_pwm_a_mode <= 1'b1;
      ecc_shutdown <= 1'b1;
      wr(BPC_OFS_CFG, 8'h03);
      settle;
      chk(pin_oe[2], 1'b0);
      wr(BPC_OFS_CFG, 8'h01);
      settle;
      chk(pin_oe[2], 1'b1);
      wr(BPC_OFS_DIR, 8'h04);
      settle;
      @(posedge hclk);
      ext_drv <= 8'h04;
      ext_lvl <= 8'h04;
      settle;
      chk(ecc_capture_in, 1'b1);
      wr(12'h010, 8'hff);
      rc(12'h010, 8'h00);
      close_out;
   end
endmodule

bind bpc_port bpc_port_props #(.WIDTH(WIDTH)) u_props (
   .hclk(hclk),
   .hresetn(hresetn),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .pin_in(pin_in),
   .pin_out(pin_out),
   .pin_oe(pin_oe),
   .timer_osc_enable(timer_osc_enable),
   .timer_osc_analog_en(timer_osc_analog_en),
   .scc_capture_in(scc_capture_in),
   .scc_on_alternate_pin(scc_on_alternate_pin),
   .ecc_capture_in(ecc_capture_in),
   .sync_ser_take(sync_ser_take),
   .sync_ser_drive(sync_ser_drive),
   .serial_pin_in(serial_pin_in)
);

`default_nettype wire
